// >>> tsp_spi_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "tsp_map.svh"

module tsp_spi_port #(
  parameter int unsigned TIMEOUT_CYC = `TSP_TIMEOUT_MS * `TSP_US_PER_MS * `TSP_CLK_MHZ,
  parameter logic [7:0] CRC_POLY = `TSP_CRC_POLY,
  parameter logic [7:0] CRC_INIT = `TSP_CRC_INIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link pins
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Configuration
  input wire logic crc_en,
  // Sensing side
  input wire logic [15:0] report_word,
  output logic report_taken,
  output tsp_pkg::tsp_cmd_s ctrl_cmd,
  output logic sense_halt,
  output logic setup_apply,
  output logic setup_bank,
  // Status
  output logic crc_error,
  output logic rx_fifo_ready,
  output logic rx_overrun
);
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic tsp_pkg::tsp_kind_e kind_of(input logic [7:0] c);
    if (c == `TSP_CODE_NULL) begin
      return tsp_pkg::K_NULL;
    end else if (c == `TSP_CODE_BULK) begin
      return tsp_pkg::K_BULK;
    end else if (c == `TSP_CODE_REPORT) begin
      return tsp_pkg::K_REPORT;
    end else if (c >= `TSP_SET_BASE && c < `TSP_SET_BASE + `TSP_SETUP_SPAN) begin
      return tsp_pkg::K_SET;
    end else if (c >= `TSP_GET_BASE && c < `TSP_GET_BASE + `TSP_SETUP_SPAN) begin
      return tsp_pkg::K_GET;
    end
    return tsp_pkg::K_CTRL;
  endfunction

  function automatic logic [5:0] addr_of(input logic [7:0] c);
    logic [7:0] d;
    d = (kind_of(c) == tsp_pkg::K_SET) ? c - `TSP_SET_BASE : c - `TSP_GET_BASE;
    return d[5:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pins are taken as synchronous; one stage of history finds the edges
  logic sck_d_reg;
  logic [2:0] bit_reg;
  logic [7:0] rx_sh_reg;
  logic [6:0] tx_sh_reg;
  logic byte_done_reg;
  logic [7:0] rx_byte_reg;
  logic sck_rise;
  logic sck_fall;
  logic to_hit;
  logic [7:0] tx_next_reg;

  assign sck_rise = ~sck_d_reg & sck & ~ss_n;
  assign sck_fall = sck_d_reg & ~sck & ~ss_n;
  assign miso_oe = ~ss_n;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck;
    end
  end

  always_ff @(posedge clk) begin
    byte_done_reg <= 1'b0;
    if (reset) begin
      bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_byte_reg <= '0;
    end else if (ss_n || to_hit) begin
      bit_reg <= '0;
    end else if (sck_rise) begin
      rx_sh_reg <= {rx_sh_reg[6:0], mosi};
      bit_reg <= bit_reg + 1'b1;
      if (bit_reg == `TSP_BIT_LAST) begin
        byte_done_reg <= 1'b1;
        rx_byte_reg <= {rx_sh_reg[6:0], mosi};
      end
    end
  end

  // First falling edge of a byte loads the reply prepared by the machine
  always_ff @(posedge clk) begin
    if (reset) begin
      miso <= 1'b1;
      tx_sh_reg <= '0;
    end else if (sck_fall) begin
      if (bit_reg == '0) begin
        miso <= tx_next_reg[7];
        tx_sh_reg <= tx_next_reg[6:0];
      end else begin
        miso <= tx_sh_reg[6];
        tx_sh_reg <= {tx_sh_reg[5:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Received bytes queue here while the machine waits on a memory read
  logic pop;
  logic rx_valid;
  logic [7:0] rx;
  logic rd_pend_reg;
  logic launch_reg;

  assign pop = rx_valid & ~rd_pend_reg & ~launch_reg;
  assign rx_overrun = byte_done_reg & ~rx_fifo_ready;

  tsp_fifo #(
    .W(8),
    .D(`TSP_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(byte_done_reg),
    .in_data(rx_byte_reg),
    .in_ready(rx_fifo_ready),
    .out_valid(rx_valid),
    .out_data(rx),
    .out_ready(~rd_pend_reg & ~launch_reg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Setup memory: two banks, bulk loads fill the idle one and then swap
  tsp_pkg::tsp_mwr_s mwr_reg;
  logic rd_req_reg;
  logic [6:0] rd_addr_reg;
  logic [7:0] mem_rdata;
  logic mem_rvalid;

  tsp_mem #(
    .AW(`TSP_MEM_AW),
    .DW(8)
  ) u_setup_mem (
    .clk(clk),
    .reset(reset),
    .we(mwr_reg.we),
    .waddr(mwr_reg.addr),
    .wdata(mwr_reg.data),
    .re(rd_req_reg),
    .raddr(rd_addr_reg),
    .rdata(mem_rdata),
    .rvalid(mem_rvalid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Inter-byte watchdog, only while a transfer is open
  tsp_pkg::tsp_state_e state_reg;
  logic [TO_W-1:0] to_cnt_reg;

  assign to_hit = (to_cnt_reg == TO_W'(TIMEOUT_CYC - 1));

  always_ff @(posedge clk) begin
    if (reset || pop || to_hit || state_reg == tsp_pkg::ST_IDLE) begin
      to_cnt_reg <= '0;
    end else begin
      to_cnt_reg <= to_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer machine
  tsp_pkg::tsp_kind_e kind_reg;
  logic crc_on_reg;
  logic [7:0] crc_reg;
  logic [7:0] rcrc_reg;
  logic [7:0] data_reg;
  logic [7:0] rep_lo_reg;
  logic [5:0] addr_reg;
  logic [5:0] bulk_cnt_reg;
  logic [1:0] left_reg;

  always_ff @(posedge clk) begin
    ctrl_cmd.valid <= 1'b0;
    mwr_reg.we <= 1'b0;
    rd_req_reg <= 1'b0;
    launch_reg <= 1'b0;
    crc_error <= 1'b0;
    setup_apply <= 1'b0;
    report_taken <= 1'b0;
    if (reset) begin
      state_reg <= tsp_pkg::ST_IDLE;
      kind_reg <= tsp_pkg::K_NULL;
      tx_next_reg <= `TSP_CODE_IDLE;
      ctrl_cmd.code <= '0;
      mwr_reg.addr <= '0;
      mwr_reg.data <= '0;
      rd_addr_reg <= '0;
      rd_pend_reg <= 1'b0;
      crc_on_reg <= 1'b0;
      crc_reg <= '0;
      rcrc_reg <= '0;
      data_reg <= '0;
      rep_lo_reg <= '0;
      addr_reg <= '0;
      bulk_cnt_reg <= '0;
      left_reg <= '0;
      sense_halt <= 1'b0;
      setup_bank <= 1'b0;
    end else if (to_hit) begin
      state_reg <= tsp_pkg::ST_IDLE;
      tx_next_reg <= `TSP_CODE_IDLE;
      rd_pend_reg <= 1'b0;
      sense_halt <= 1'b0;
    end else if (mem_rvalid) begin
      tx_next_reg <= mem_rdata;
      rcrc_reg <= crc8(rcrc_reg, mem_rdata);
      rd_pend_reg <= 1'b0;
    end else if (launch_reg) begin
      unique case (kind_reg)
        tsp_pkg::K_GET: begin
          rd_req_reg <= 1'b1;
          rd_addr_reg <= {setup_bank, addr_reg};
          rd_pend_reg <= 1'b1;
          rcrc_reg <= CRC_INIT;
          left_reg <= `TSP_REPLY_ONE;
          state_reg <= tsp_pkg::ST_REPLY;
        end
        tsp_pkg::K_REPORT: begin
          tx_next_reg <= report_word[15:8];
          rep_lo_reg <= report_word[7:0];
          rcrc_reg <= crc8(CRC_INIT, report_word[15:8]);
          report_taken <= 1'b1;
          left_reg <= `TSP_REPORT_LEN;
          state_reg <= tsp_pkg::ST_REPLY;
        end
        default: begin
          ctrl_cmd.valid <= 1'b1;
          ctrl_cmd.code <= data_reg;
          state_reg <= tsp_pkg::ST_IDLE;
          tx_next_reg <= `TSP_CODE_IDLE;
        end
      endcase
    end else if (pop) begin
      unique case (state_reg)
        tsp_pkg::ST_IDLE: begin
          crc_on_reg <= crc_en;
          crc_reg <= crc8(CRC_INIT, rx);
          kind_reg <= kind_of(rx);
          addr_reg <= addr_of(rx);
          data_reg <= rx;
          unique case (kind_of(rx))
            tsp_pkg::K_NULL: begin
              tx_next_reg <= `TSP_CODE_IDLE;
            end
            tsp_pkg::K_BULK: begin
              sense_halt <= 1'b1;
              bulk_cnt_reg <= '0;
              tx_next_reg <= `TSP_CODE_IDLE;
              state_reg <= tsp_pkg::ST_BULK;
            end
            tsp_pkg::K_SET: begin
              tx_next_reg <= rx;
              state_reg <= tsp_pkg::ST_SETDATA;
            end
            default: begin
              if (crc_en) begin
                tx_next_reg <= crc8(CRC_INIT, rx);
                state_reg <= tsp_pkg::ST_CMDCRC;
              end else begin
                launch_reg <= 1'b1;
              end
            end
          endcase
        end
        tsp_pkg::ST_BULK: begin
          mwr_reg.we <= 1'b1;
          mwr_reg.addr <= {~setup_bank, bulk_cnt_reg};
          mwr_reg.data <= rx;
          crc_reg <= crc8(crc_reg, rx);
          bulk_cnt_reg <= bulk_cnt_reg + 1'b1;
          if (bulk_cnt_reg == `TSP_BULK_LAST) begin
            if (crc_on_reg) begin
              tx_next_reg <= crc8(crc_reg, rx);
              state_reg <= tsp_pkg::ST_CMDCRC;
            end else begin
              setup_bank <= ~setup_bank;
              setup_apply <= 1'b1;
              sense_halt <= 1'b0;
              tx_next_reg <= `TSP_CODE_IDLE;
              state_reg <= tsp_pkg::ST_IDLE;
            end
          end
        end
        tsp_pkg::ST_SETDATA: begin
          data_reg <= rx;
          crc_reg <= crc8(crc_reg, rx);
          if (crc_on_reg) begin
            tx_next_reg <= crc8(crc_reg, rx);
            state_reg <= tsp_pkg::ST_CMDCRC;
          end else begin
            mwr_reg.we <= 1'b1;
            mwr_reg.addr <= {setup_bank, addr_reg};
            mwr_reg.data <= rx;
            tx_next_reg <= `TSP_CODE_IDLE;
            state_reg <= tsp_pkg::ST_IDLE;
          end
        end
        tsp_pkg::ST_CMDCRC: begin
          tx_next_reg <= `TSP_CODE_IDLE;
          state_reg <= tsp_pkg::ST_IDLE;
          sense_halt <= 1'b0;
          if (rx == crc_reg) begin
            unique case (kind_reg)
              tsp_pkg::K_SET: begin
                mwr_reg.we <= 1'b1;
                mwr_reg.addr <= {setup_bank, addr_reg};
                mwr_reg.data <= data_reg;
              end
              tsp_pkg::K_BULK: begin
                setup_bank <= ~setup_bank;
                setup_apply <= 1'b1;
              end
              default: begin
                launch_reg <= 1'b1;
              end
            endcase
          end else begin
            // Mismatch drops the whole transfer; a bulk load keeps old settings
            crc_error <= 1'b1;
          end
        end
        tsp_pkg::ST_REPLY: begin
          if (left_reg == `TSP_REPORT_LEN) begin
            tx_next_reg <= rep_lo_reg;
            rcrc_reg <= crc8(rcrc_reg, rep_lo_reg);
            left_reg <= `TSP_REPLY_ONE;
          end else if (crc_on_reg) begin
            tx_next_reg <= rcrc_reg;
            state_reg <= tsp_pkg::ST_RCRC;
          end else begin
            tx_next_reg <= `TSP_CODE_IDLE;
            state_reg <= tsp_pkg::ST_IDLE;
          end
        end
        tsp_pkg::ST_RCRC: begin
          tx_next_reg <= `TSP_CODE_IDLE;
          state_reg <= tsp_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tsp_map.svh
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH
// Byte codes seen on the serial link
`define TSP_CODE_IDLE 8'h55
`define TSP_CODE_NULL 8'h00
`define TSP_CODE_BULK 8'h01
`define TSP_CODE_REPORT 8'hC1
// Set and get code windows, one code per setup address
`define TSP_SET_BASE 8'h90
`define TSP_GET_BASE 8'h60
`define TSP_SETUP_SPAN 8'h30
// Bulk setup load carries 42 data bytes, index of the last one
`define TSP_BULK_LAST 6'h29
`define TSP_REPORT_LEN 2'h2
`define TSP_REPLY_ONE 2'h1
`define TSP_BIT_LAST 3'h7
// CRC defaults, overridable by parameter
`define TSP_CRC_POLY 8'h07
`define TSP_CRC_INIT 8'h00
// Timing and sizes
`define TSP_CLK_MHZ 250
`define TSP_TIMEOUT_MS 100
`define TSP_US_PER_MS 1000
`define TSP_FIFO_DEPTH 4
`define TSP_MEM_AW 7
`endif

// >>> tsp_pkg.sv
`default_nettype none
package tsp_pkg;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_BULK    = 6'h02,
    ST_SETDATA = 6'h04,
    ST_CMDCRC  = 6'h08,
    ST_REPLY   = 6'h10,
    ST_RCRC    = 6'h20
  } tsp_state_e;

  typedef enum logic [2:0] {
    K_NULL   = 3'h0,
    K_CTRL   = 3'h1,
    K_SET    = 3'h2,
    K_GET    = 3'h3,
    K_REPORT = 3'h4,
    K_BULK   = 3'h5
  } tsp_kind_e;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } tsp_cmd_s;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } tsp_mwr_s;

endpackage
`default_nettype wire

// >>> tsp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module tsp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> tsp_mem.sv
`timescale 1ns/1ns
`default_nettype none
module tsp_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port, data one cycle after the request
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata,
  output logic rvalid
);
  logic [DW-1:0] mem_reg [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= re;
      if (re) begin
        rdata <= mem_reg[raddr];
      end
    end
  end
endmodule
`default_nettype wire

// >>> tsp_spi_port_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tsp_spi_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic sck,
  input wire logic ss_n,
  input wire logic miso,
  input wire logic miso_oe,
  // Sensing side
  input wire logic report_taken,
  input wire tsp_pkg::tsp_cmd_s ctrl_cmd,
  input wire logic sense_halt,
  input wire logic setup_apply,
  input wire logic setup_bank,
  input wire logic crc_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  a_miso_shift_edge: assert property (!ss_n && !$stable(miso) |-> !sck)
    else $error("miso moved while sck high");
  a_oe_follows_sel: assert property (miso_oe == !ss_n)
    else $error("miso enable differs from select");
  a_ctrl_single: assert property (ctrl_cmd.valid |=> !ctrl_cmd.valid)
    else $error("control strobe longer than one cycle");
  a_report_single: assert property (report_taken |=> !report_taken)
    else $error("report strobe longer than one cycle");
  a_apply_in_load: assert property (setup_apply |-> sense_halt || $past(sense_halt))
    else $error("setup applied outside a bulk load");
  a_bank_swap: assert property (setup_apply |-> setup_bank != $past(setup_bank))
    else $error("bank did not swap on apply");
  a_bank_hold: assert property (!setup_apply |-> $stable(setup_bank))
    else $error("bank changed without apply");
  a_halt_no_ctrl: assert property (sense_halt |-> !ctrl_cmd.valid)
    else $error("control issued during bulk load");
  a_crc_err_single: assert property (crc_error |=> !crc_error)
    else $error("crc error strobe longer than one cycle");
  // Reset itself must not disable this one
  a_reset_quiet: assert property (disable iff (1'h0) reset |=> miso && !sense_halt && !setup_bank)
    else $error("outputs not at rest after reset");
  c_ctrl: cover property (ctrl_cmd.valid);
  c_report: cover property (report_taken);
  c_apply: cover property (setup_apply);
  c_crc_err: cover property (crc_error);
endmodule
bind tsp_spi_port tsp_spi_port_chk chk (.clk(clk), .reset(reset), .sck(sck), .ss_n(ss_n),
  .miso(miso), .miso_oe(miso_oe), .report_taken(report_taken), .ctrl_cmd(ctrl_cmd),
  .sense_halt(sense_halt), .setup_apply(setup_apply), .setup_bank(setup_bank),
  .crc_error(crc_error));
`default_nettype wire

// >>> tsp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tsp_host_model #(
  parameter int HALF = 84,
  parameter int GAP = 37500
) (
  // Clock
  input wire logic clk,
  // Link
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'h1;
    ss_n = 1'h1;
    mosi = 1'h1;
  end
  ////////////////////////////////////////////////////////////////
  // HALF sets the serial rate in clock cycles per half bit; GAP sets the idle cycles after each byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge clk);
    ss_n = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      repeat (HALF) @(negedge clk);
      sck = 1'h0;
      mosi = tx[i];
      repeat (HALF) @(negedge clk);
      sck = 1'h1;
      rx[i] = miso;
    end
    repeat (HALF) @(negedge clk);
    ss_n = 1'h1;
    // Released line shows the inverse, not a stale bit
    mosi = ~mosi;
    repeat (GAP) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tsp_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tsp_map.svh"
module tb;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic crc_en = 1'h0;
  logic [15:0] report_word = 16'hB4C3;
  logic sck, ss_n, mosi, miso, report_taken, sense_halt, setup_apply, setup_bank, crc_error;
  logic miso_oe, miso_line, rx_fifo_ready, rx_overrun;
  tsp_pkg::tsp_cmd_s ctrl_cmd;
  logic [7:0] last_code;
  int failures = 0;
  int check_count = 0;
  int n_ctrl = 0, n_rep = 0, n_apply = 0, n_err = 0, n_ovr = 0;
  always #2 clk = ~clk;
  tsp_spi_port #(.TIMEOUT_CYC(400)) uut (.clk(clk), .reset(reset), .sck(sck), .ss_n(ss_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .crc_en(crc_en), .report_word(report_word),
    .report_taken(report_taken), .ctrl_cmd(ctrl_cmd), .sense_halt(sense_halt),
    .setup_apply(setup_apply), .setup_bank(setup_bank), .crc_error(crc_error),
    .rx_fifo_ready(rx_fifo_ready), .rx_overrun(rx_overrun));
  // Deselected line shows the inverse, so a sample taken while released is caught
  assign miso_line = miso_oe ? miso : ~miso;
  // Fast link and short gaps keep the run short; timeout shrunk to match
  tsp_host_model #(.HALF(8), .GAP(40)) host (.clk(clk), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso(miso_line));
  // Counted on the falling edge, clear of the edge that launches each pulse
  always @(negedge clk) begin
    if (ctrl_cmd.valid === 1'h1) begin
      n_ctrl++;
      last_code = ctrl_cmd.code;
    end
    if (report_taken === 1'h1) n_rep++;
    if (setup_apply === 1'h1) n_apply++;
    if (crc_error === 1'h1) n_err++;
    if (rx_overrun === 1'h1) n_ovr++;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'h0} ^ `TSP_CRC_POLY : {c[6:0], 1'h0};
    return c;
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xb(input logic [7:0] tx, input logic [7:0] ex, input string what);
    logic [7:0] rx;
    host.xfer(tx, rx);
    check(what, {8'h00, ex}, {8'h00, rx});
  endtask
  task automatic set_crc(input logic v);
    @(negedge clk);
    crc_en = v;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_ctrl();
    int n;
    logic [7:0] c;
    n = n_ctrl;
    c = crc_step(`TSP_CRC_INIT, 8'h12);
    set_crc(1'h0);
    xb(8'h12, `TSP_CODE_IDLE, "ctrl idle");
    check("ctrl count", 16'(n + 1), 16'(n_ctrl));
    check("ctrl code", 16'h0012, {8'h00, last_code});
    xb(`TSP_CODE_NULL, `TSP_CODE_IDLE, "null idle");
    check("null no ctrl", 16'(n + 1), 16'(n_ctrl));
    set_crc(1'h1);
    xb(8'h12, `TSP_CODE_IDLE, "ctrl crc idle");
    check("ctrl early", 16'(n + 1), 16'(n_ctrl));
    xb(c, c, "ctrl crc echo");
    check("ctrl after crc", 16'(n + 2), 16'(n_ctrl));
    xb(8'h12, `TSP_CODE_IDLE, "ctrl bad idle");
    xb(~c, c, "ctrl bad echo");
    check("ctrl refused", 16'(n + 2), 16'(n_ctrl));
    check("crc error", 16'h0001, 16'(n_err));
    $display("test ctrl done");
  endtask
  task automatic t_report();
    logic [7:0] c;
    c = crc_step(crc_step(`TSP_CRC_INIT, 8'hB4), 8'hC3);
    set_crc(1'h0);
    xb(`TSP_CODE_REPORT, `TSP_CODE_IDLE, "rep idle");
    xb(`TSP_CODE_NULL, 8'hB4, "rep hi");
    xb(`TSP_CODE_NULL, 8'hC3, "rep lo");
    set_crc(1'h1);
    xb(`TSP_CODE_REPORT, `TSP_CODE_IDLE, "rep crc idle");
    xb(crc_step(`TSP_CRC_INIT, 8'hC1), crc_step(`TSP_CRC_INIT, 8'hC1), "rep req crc");
    xb(`TSP_CODE_NULL, 8'hB4, "rep crc hi");
    xb(`TSP_CODE_NULL, 8'hC3, "rep crc lo");
    xb(`TSP_CODE_NULL, c, "rep data crc");
    check("report taken", 16'h0002, 16'(n_rep));
    $display("test report done");
  endtask
  task automatic t_setget();
    logic [7:0] c;
    c = crc_step(crc_step(`TSP_CRC_INIT, 8'h96), 8'hA5);
    set_crc(1'h0);
    xb(8'h95, `TSP_CODE_IDLE, "set idle");
    xb(8'h3C, 8'h95, "set echo");
    xb(8'h65, `TSP_CODE_IDLE, "get idle");
    xb(`TSP_CODE_NULL, 8'h3C, "get data");
    set_crc(1'h1);
    xb(8'h96, `TSP_CODE_IDLE, "set crc idle");
    xb(8'hA5, 8'h96, "set crc echo");
    xb(c, c, "set crc");
    xb(8'h96, `TSP_CODE_IDLE, "bad set idle");
    xb(8'h11, 8'h96, "bad set echo");
    xb(8'h00, crc_step(crc_step(`TSP_CRC_INIT, 8'h96), 8'h11), "bad set crc");
    c = crc_step(`TSP_CRC_INIT, 8'h66);
    xb(8'h66, `TSP_CODE_IDLE, "get crc idle");
    xb(c, c, "get req crc");
    xb(`TSP_CODE_NULL, 8'hA5, "get kept");
    xb(`TSP_CODE_NULL, crc_step(`TSP_CRC_INIT, 8'hA5), "get reply crc");
    check("set crc error", 16'h0002, 16'(n_err));
    $display("test setget done");
  endtask
  task automatic t_timeout();
    int n;
    n = n_ctrl;
    set_crc(1'h0);
    xb(8'h95, `TSP_CODE_IDLE, "stale set");
    repeat (700) @(negedge clk);
    xb(8'h12, `TSP_CODE_IDLE, "fresh cmd");
    check("fresh ctrl", 16'(n + 1), 16'(n_ctrl));
    $display("test timeout done");
  endtask
  task automatic t_bulk();
    logic [7:0] c;
    c = crc_step(`TSP_CRC_INIT, `TSP_CODE_BULK);
    set_crc(1'h1);
    xb(`TSP_CODE_BULK, `TSP_CODE_IDLE, "bulk idle");
    check("halt", 16'h0001, {15'h0000, sense_halt});
    for (int i = 0; i < 42; i++) begin
      xb(8'h20 + 8'(i), `TSP_CODE_IDLE, "bulk data");
      c = crc_step(c, 8'h20 + 8'(i));
    end
    check("no early apply", 16'h0000, 16'(n_apply));
    xb(c, c, "bulk crc");
    check("apply", 16'h0001, 16'(n_apply));
    check("resume", 16'h0000, {15'h0000, sense_halt});
    set_crc(1'h0);
    xb(8'h63, `TSP_CODE_IDLE, "bulk get idle");
    xb(`TSP_CODE_NULL, 8'h23, "bulk get data");
    check("no overrun", 16'h0000, 16'(n_ovr));
    check("fifo ready", 16'h0001, {15'h0000, rx_fifo_ready});
    $display("test bulk done");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'h0;
    t_ctrl();
    t_report();
    t_setget();
    t_timeout();
    t_bulk();
    print_verdict();
  end
  // About 75 bytes of some 177 cycles each, with ample margin
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
`default_nettype wire
